/* File: hdl/usbrx_pkg.sv */
// constants for the endpoint receive fifo access and register decode block
package usbrx_pkg;

	// upper address bits that select the register read, register write and fifo read pages
	localparam logic [1:0] USBRX_SEL_REG_RD  = 2'h3;
	localparam logic [1:0] USBRX_SEL_REG_WR  = 2'h1;
	localparam logic [1:0] USBRX_SEL_FIFO_RD = 2'h1;

	// register offsets within a page (address bits 5:0)
	localparam logic [5:0] OFS_EP0_RX_CONTROL = 6'h20;
	localparam logic [5:0] OFS_EP0_RX_TOGGLE  = 6'h21;
	localparam logic [5:0] OFS_EP0_RX_PAYLOAD = 6'h22;
	localparam logic [5:0] OFS_EP1_CONTROL    = 6'h24;
	localparam logic [5:0] OFS_EP1_TOGGLE     = 6'h25;
	localparam logic [5:0] OFS_EP1_PAYLOAD    = 6'h26;
	localparam logic [5:0] OFS_EP0_TX_CONTROL = 6'h30;
	localparam logic [5:0] OFS_EP0_TX_TOGGLE  = 6'h31;
	localparam logic [5:0] OFS_EP0_TX_PAYLOAD = 6'h32;
	localparam logic [5:0] OFS_EP0_STATE      = 6'h33;
	localparam logic [5:0] OFS_EP2_CONTROL    = 6'h34;
	localparam logic [5:0] OFS_EP2_TOGGLE     = 6'h35;
	localparam logic [5:0] OFS_EP2_PAYLOAD    = 6'h36;
	localparam logic [5:0] OFS_EP3_CONTROL    = 6'h38;
	localparam logic [5:0] OFS_EP3_TOGGLE     = 6'h39;
	localparam logic [5:0] OFS_EP3_PAYLOAD    = 6'h3A;
	localparam logic [5:0] OFS_PACKET_READY   = 6'h08;
	localparam logic [5:0] OFS_EP0_RX_FIFO    = 6'h00;
	localparam logic [5:0] OFS_EP1_RX_FIFO    = 6'h01;

	// number of software-writable storage registers
	localparam int USBRX_RW_SLOTS = 12;

	// field positions
	localparam int BIT_RDY_EP0      = 0;
	localparam int BIT_RDY_EP1      = 1;
	localparam int BIT_EP0_STALL    = 2;
	localparam int BIT_EP1_STALL    = 1;
	localparam int BIT_EP1_DIR_TX   = 7;

	// reset values, and the value read at unmapped offsets
	localparam logic [7:0]  RST_REG_VALUE = 8'h00;
	localparam logic [15:0] RST_DATA_OUT  = 16'h0000;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;

	// fifo depths
	localparam int EP0_RX_DEPTH = 8;
	localparam int EP1_RX_DEPTH = 64;

endpackage

/* File: hdl/usbrx_top.sv */
// endpoint 0/1 receive fifos, their processor read path and endpoint register decode
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module usbrx_fifo #(
	parameter int DEPTH = 8
) (
	input  wire logic       clk,       // block clock
	input  wire logic       rst_b,     // async reset, active low
	input  wire logic       flush,     // empty the fifo
	input  wire logic       wr_valid,  // one byte from the packet engine
	input  wire logic [7:0] wr_data,   // byte to store
	input  wire logic       pop1,      // take one byte
	input  wire logic       pop2,      // take two bytes
	output logic      [7:0] rd_lo,     // byte at the read pointer
	output logic      [7:0] rd_hi,     // byte after it, 00 if none
	output logic            has_one,   // at least one byte stored
	output logic            has_two    // at least two bytes stored
);
	// rd_lo feeds byte reads and rd_hi the upper half of a dma word;
	// depth is a parameter so one body serves the 8-byte control fifo
	// and the 64-byte bulk fifo; the pointers never wrap, so a new packet
	// must follow a flush, which the engine's token and setup pulses give
	localparam int PW = $clog2(DEPTH + 1);

	logic [7:0]    mem [0:DEPTH-1];
	logic [PW-1:0] wcnt_ff;
	logic [PW-1:0] rcnt_ff;
	logic [PW-1:0] rnext;

	// pointers count bytes; no wrap since the write count stops at the depth
	assign rnext   = PW'(rcnt_ff + 1'b1);
	assign has_one = rcnt_ff < wcnt_ff;
	assign has_two = rnext < wcnt_ff;
	assign rd_lo   = has_one ? mem[rcnt_ff[PW-1:0] % DEPTH] : 8'h00;
	assign rd_hi   = has_two ? mem[rnext % DEPTH] : 8'h00;

	// storage is not reset: contents after any reset are undefined
	always_ff @(posedge clk) begin
		if (wr_valid && !flush && (wcnt_ff < PW'(DEPTH))) begin
			mem[wcnt_ff % DEPTH] <= wr_data;
		end
	end

	// write side; a flush empties it, bytes past the depth are dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wcnt_ff <= '0;
		end else if (flush) begin
			wcnt_ff <= '0;
		end else if (wr_valid && (wcnt_ff < PW'(DEPTH))) begin
			wcnt_ff <= PW'(wcnt_ff + 1'b1);
		end
	end

	// read side steps one or two bytes per access, never past the stored end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rcnt_ff <= '0;
		end else if (flush) begin
			rcnt_ff <= '0;
		end else if (pop2 && has_two) begin
			rcnt_ff <= PW'(rcnt_ff + 2'd2);
		end else if ((pop1 || pop2) && has_one) begin
			rcnt_ff <= rnext;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module usbrx_top
	import usbrx_pkg::*;
#(
	parameter int EP0_DEPTH = usbrx_pkg::EP0_RX_DEPTH,
	parameter int EP1_DEPTH = usbrx_pkg::EP1_RX_DEPTH
) (
	input  wire logic        CLK,            // 100 MHz block clock
	input  wire logic        RST_B,          // async hardware reset, active low
	input  wire logic        CS_B,           // chip select, active low
	input  wire logic        RD_B,           // read strobe, active low
	input  wire logic        WR_B,           // write strobe, active low
	input  wire logic        DACK_B,         // dma acknowledge, active low
	input  wire logic [7:0]  A,              // full address A7:A0
	input  wire logic [15:0] D_IN,           // data bus as seen on the pins
	output logic      [15:0] D_OUT,          // data driven onto the bus
	output logic             D_OE_B,         // bus driven while low
	input  wire logic        RX_VALID,       // one received byte
	input  wire logic        RX_EP,          // endpoint of the byte, 0 or 1
	input  wire logic [7:0]  RX_DATA,        // received byte
	input  wire logic        RX_DONE,        // end of a data packet
	input  wire logic        RX_ERR,         // packet ended in error, with RX_DONE
	input  wire logic        SETUP_SEEN,     // setup packet arrived for ep0
	input  wire logic        OUT_TOKEN_EP1,  // out token for ep1
	input  wire logic        USB_BUS_RESET,  // usb bus reset pulse
	input  wire logic [7:0]  EP0_RX_CTRL_IN, // engine state for ep0 rx control
	input  wire logic [7:0]  EP0_RX_TGL_IN,  // engine state for ep0 rx toggle
	input  wire logic [7:0]  EP0_TX_CTRL_IN, // engine state for ep0 tx control
	input  wire logic [7:0]  EP0_TX_TGL_IN,  // engine state for ep0 tx toggle
	output logic      [1:0]  PKT_RDY,        // receive packet ready flags ep1:ep0
	output logic             EP0_STALL,      // ep0 stall bit
	output logic             EP1_STALL,      // ep1 stall bit
	output logic             EP1_DIR_TX      // ep1 set for transmit
);
	import usbrx_pkg::*;

	// maps a writable register offset to its storage slot, 4'hF if none
	function automatic logic [3:0] rw_slot(input logic [5:0] ofs);
		logic [3:0] s;
		s = 4'hF;
		unique case (ofs)
			OFS_EP0_RX_PAYLOAD: s = 4'h0;
			OFS_EP1_CONTROL:    s = 4'h1;
			OFS_EP1_TOGGLE:     s = 4'h2;
			OFS_EP1_PAYLOAD:    s = 4'h3;
			OFS_EP0_TX_PAYLOAD: s = 4'h4;
			OFS_EP0_STATE:      s = 4'h5;
			OFS_EP2_CONTROL:    s = 4'h6;
			OFS_EP2_TOGGLE:     s = 4'h7;
			OFS_EP2_PAYLOAD:    s = 4'h8;
			OFS_EP3_CONTROL:    s = 4'h9;
			OFS_EP3_TOGGLE:     s = 4'hA;
			OFS_EP3_PAYLOAD:    s = 4'hB;
			default:            s = 4'hF;
		endcase
		return s;
	endfunction

	// slots whose bits leave the block as pins or steer the fifos;
	// the slot numbers are private to this module, only the offsets
	// are visible to software, so they may be shuffled freely
	// as long as rw_slot above is changed with them
	localparam logic [3:0] SLOT_EP1_CONTROL = 4'h1;
	localparam logic [3:0] SLOT_EP0_STATE   = 4'h5;

	logic [7:0]  rw_ff [0:USBRX_RW_SLOTS-1];
	logic        rd_prev_ff;
	logic        wr_prev_ff;
	logic [1:0]  rdy_ff;
	logic [15:0] d_out_ff;
	logic        d_oe_b_ff;

	logic        rd_evt;
	logic        wr_evt;
	logic        dma_evt;
	logic        reg_rd;
	logic        reg_wr;
	logic [3:0]  wslot;
	logic        ep1_tx;
	logic        ep1_blocked;
	logic        pop0;
	logic        pop1_one;
	logic        pop1_two;
	logic        set0;
	logic        set1;
	logic        rel0;
	logic        rel1;
	logic        stall0_off;
	logic        stall1_off;
	logic        flush0;
	logic        flush1;
	logic        err0;
	logic        err1;
	logic [7:0]  f0_lo;
	logic [7:0]  f1_lo;
	logic [7:0]  f1_hi;
	logic [7:0]  reg_data;
	logic [15:0] nxt_d_out;

	////////////////////////////////////////////////////////////////////////

	// strobe edges: pins are synchronous, so one access is one falling edge
	// a strobe held low over many cycles still pops only once, which is
	// what lets a slow processor stretch its read without losing bytes
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_prev_ff <= 1'b1;
			wr_prev_ff <= 1'b1;
		end else begin
			rd_prev_ff <= RD_B;
			wr_prev_ff <= WR_B;
		end
	end

	// a dma acknowledge turns the read into an ep1 fifo word read at 41h
	assign dma_evt = !DACK_B && !RD_B && rd_prev_ff;
	assign rd_evt  = DACK_B && !CS_B && !RD_B && rd_prev_ff;
	assign wr_evt  = !CS_B && !WR_B && wr_prev_ff;
	assign reg_rd  = rd_evt && (A[7:6] == USBRX_SEL_REG_RD);
	assign reg_wr  = wr_evt && (A[7:6] == USBRX_SEL_REG_WR);
	assign wslot   = reg_wr ? rw_slot(A[5:0]) : 4'hF;
	assign ep1_tx  = rw_ff[SLOT_EP1_CONTROL][BIT_EP1_DIR_TX];

	// fifo pops; ep1 accesses are dropped whole while it transmits
	assign pop0     = rd_evt && (A[7:6] == USBRX_SEL_FIFO_RD)
		&& (A[5:0] == OFS_EP0_RX_FIFO);
	assign pop1_one = rd_evt && (A[7:6] == USBRX_SEL_FIFO_RD)
		&& (A[5:0] == OFS_EP1_RX_FIFO) && !ep1_tx;
	assign pop1_two = dma_evt && (A == {USBRX_SEL_FIFO_RD, OFS_EP1_RX_FIFO}) && !ep1_tx;

	// an ep1 fifo access while transmitting leaves the fifo and read data alone
	assign ep1_blocked = ep1_tx && (A == {USBRX_SEL_FIFO_RD, OFS_EP1_RX_FIFO});

	////////////////////////////////////////////////////////////////////////

	// packet ready set and release; a set in the same cycle beats the release
	// trade-off: a release racing a new packet end keeps the new packet,
	// so software sees the flag again rather than losing data silently
	assign err0 = RX_DONE && RX_ERR && !RX_EP;
	assign err1 = RX_DONE && RX_ERR && RX_EP;
	assign set0 = RX_DONE && !RX_ERR && !RX_EP;
	assign set1 = RX_DONE && !RX_ERR && RX_EP;
	assign rel0 = reg_wr && (A[5:0] == OFS_PACKET_READY) && D_IN[BIT_RDY_EP0] && !set0;
	assign rel1 = reg_wr && (A[5:0] == OFS_PACKET_READY) && D_IN[BIT_RDY_EP1] && !set1;

	// stall removal means any write that leaves the stall bit at 0
	assign stall0_off = (wslot == SLOT_EP0_STATE) && !D_IN[BIT_EP0_STALL];
	assign stall1_off = (wslot == SLOT_EP1_CONTROL) && !D_IN[BIT_EP1_STALL];

	// a bad packet is thrown away so its partial data is never offered
	assign flush0 = rel0 || SETUP_SEEN || stall0_off || err0 || USB_BUS_RESET;
	assign flush1 = rel1 || OUT_TOKEN_EP1 || stall1_off || err1 || USB_BUS_RESET;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdy_ff <= 2'h0;
		end else begin
			if (set0) begin
				rdy_ff[BIT_RDY_EP0] <= 1'b1;
			end else if (rel0 || SETUP_SEEN || stall0_off || USB_BUS_RESET) begin
				rdy_ff[BIT_RDY_EP0] <= 1'b0;
			end
			if (set1) begin
				rdy_ff[BIT_RDY_EP1] <= 1'b1;
			end else if (rel1 || OUT_TOKEN_EP1 || stall1_off || USB_BUS_RESET) begin
				rdy_ff[BIT_RDY_EP1] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	// the two receive fifos; bytes route by endpoint from the engine
	usbrx_fifo #(
		.DEPTH(EP0_DEPTH)
	) u_ep0 (
		.clk     (CLK),
		.rst_b   (RST_B),
		.flush   (flush0),
		.wr_valid(RX_VALID && !RX_EP),
		.wr_data (RX_DATA),
		.pop1    (pop0),
		.pop2    (1'b0),
		.rd_lo   (f0_lo),
		.rd_hi   (),
		.has_one (),
		.has_two ()
	);

	usbrx_fifo #(
		.DEPTH(EP1_DEPTH)
	) u_ep1 (
		.clk     (CLK),
		.rst_b   (RST_B),
		.flush   (flush1),
		.wr_valid(RX_VALID && RX_EP),
		.wr_data (RX_DATA),
		.pop1    (pop1_one),
		.pop2    (pop1_two),
		.rd_lo   (f1_lo),
		.rd_hi   (f1_hi),
		.has_one (),
		.has_two ()
	);

	////////////////////////////////////////////////////////////////////////

	// writable endpoint registers; read-only offsets have no slot at all
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < USBRX_RW_SLOTS; i++) begin
				rw_ff[i] <= RST_REG_VALUE;
			end
		end else if (wslot != 4'hF) begin
			rw_ff[wslot] <= D_IN[7:0];
		end
	end

	// register read mux; reserved and unknown offsets read as zero
	// the page bits are checked by the caller, not here
	always_comb begin
		reg_data = UNMAPPED_READ;
		unique case (A[5:0])
			OFS_EP0_RX_CONTROL: reg_data = EP0_RX_CTRL_IN;
			OFS_EP0_RX_TOGGLE:  reg_data = EP0_RX_TGL_IN;
			OFS_EP0_TX_CONTROL: reg_data = EP0_TX_CTRL_IN;
			OFS_EP0_TX_TOGGLE:  reg_data = EP0_TX_TGL_IN;
			OFS_PACKET_READY:   reg_data = {6'h00, rdy_ff};
			default: begin
				if (rw_slot(A[5:0]) != 4'hF) begin
					reg_data = rw_ff[rw_slot(A[5:0])];
				end
			end
		endcase
	end

	// data held between accesses; the byte is captured on the strobe edge
	// an ignored ep1 access keeps the last value, so a stray read during
	// transmit neither pops a byte nor shows a fake one
	always_comb begin
		nxt_d_out = d_out_ff;
		if (pop1_two) begin
			nxt_d_out = {f1_hi, f1_lo};
		end else if (pop0) begin
			nxt_d_out = {8'h00, f0_lo};
		end else if (pop1_one) begin
			nxt_d_out = {8'h00, f1_lo};
		end else if (reg_rd) begin
			nxt_d_out = {8'h00, reg_data};
		end else if ((rd_evt || dma_evt) && !ep1_blocked) begin
			nxt_d_out = {8'h00, UNMAPPED_READ};
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			d_out_ff  <= RST_DATA_OUT;
			d_oe_b_ff <= 1'b1;
		end else begin
			d_out_ff  <= nxt_d_out;
			// an ignored ep1 access still drives nothing harmful: last value
			d_oe_b_ff <= !(!RD_B && (!CS_B || !DACK_B));
		end
	end

	////////////////////////////////////////////////////////////////////////

	// outputs, all straight from flip-flops
	// keeping them registered hides the decode glitches from the pins
	assign D_OUT      = d_out_ff;
	assign D_OE_B     = d_oe_b_ff;
	assign PKT_RDY    = rdy_ff;
	assign EP0_STALL  = rw_ff[SLOT_EP0_STATE][BIT_EP0_STALL];
	assign EP1_STALL  = rw_ff[SLOT_EP1_CONTROL][BIT_EP1_STALL];
	assign EP1_DIR_TX = ep1_tx;
endmodule

/* File: bench/usbrx_props.sv */
// concurrent checks on the receive fifo access block ports
`timescale 1ns/1ps

module usbrx_props (
	input wire logic        CLK,            // clock
	input wire logic        RST_B,          // reset
	input wire logic        CS_B,           // select
	input wire logic        RD_B,           // read
	input wire logic        WR_B,           // write
	input wire logic [7:0]  A,              // address
	input wire logic [15:0] D_IN,           // write data
	input wire logic [15:0] D_OUT,          // read data
	input wire logic        D_OE_B,         // drive enable
	input wire logic        RX_EP,          // byte endpoint
	input wire logic        RX_DONE,        // packet end
	input wire logic        RX_ERR,         // bad packet
	input wire logic        SETUP_SEEN,     // setup
	input wire logic        USB_BUS_RESET,  // bus reset
	input wire logic [7:0]  EP0_RX_CTRL_IN, // shown at 20h
	input wire logic [1:0]  PKT_RDY,        // ready flags
	input wire logic        EP0_STALL,      // ep0 stall
	input wire logic        EP1_DIR_TX      // ep1 direction
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	// the flag may only follow a clean packet end on its endpoint
	AST_RDY_RISE: assert property ($rose(PKT_RDY[0]) |-> $past(RX_DONE && !RX_ERR && !RX_EP))
		else $error("ep0 ready rose without a good packet end");
	AST_ERR_PKT: assert property ((RX_DONE && RX_ERR && !RX_EP && !PKT_RDY[0]) |=> !PKT_RDY[0])
		else $error("ep0 ready set by a bad packet");
	AST_SETUP: assert property ((SETUP_SEEN && !RX_DONE) |=> !PKT_RDY[0])
		else $error("ep0 ready kept after setup");
	AST_BUSRST: assert property ((USB_BUS_RESET && !RX_DONE) |=> (PKT_RDY == 2'h0))
		else $error("ready flags kept after bus reset");
	// read answer comes one edge after the strobe is taken
	AST_OE: assert property (($fell(RD_B) && !CS_B) |=> !D_OE_B)
		else $error("bus not driven after a read");
	AST_RO_READ: assert property (($fell(RD_B) && !CS_B && A == 8'hE0) |=> (D_OUT == {8'h00, $past(EP0_RX_CTRL_IN)}))
		else $error("ep0 rx control read wrong");
	AST_STALL: assert property (($fell(WR_B) && !CS_B && A == 8'h73) |=> (EP0_STALL == $past(D_IN[2])))
		else $error("ep0 stall not written");
	AST_DIR: assert property (($fell(WR_B) && !CS_B && A == 8'h64) |=> (EP1_DIR_TX == $past(D_IN[7])))
		else $error("ep1 direction not written");
endmodule

bind usbrx_top usbrx_props u_usbrx_props (.CLK(CLK), .RST_B(RST_B), .CS_B(CS_B), .RD_B(RD_B),
	.WR_B(WR_B), .A(A), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_B(D_OE_B), .RX_EP(RX_EP),
	.RX_DONE(RX_DONE), .RX_ERR(RX_ERR), .SETUP_SEEN(SETUP_SEEN), .USB_BUS_RESET(USB_BUS_RESET),
	.EP0_RX_CTRL_IN(EP0_RX_CTRL_IN), .PKT_RDY(PKT_RDY), .EP0_STALL(EP0_STALL),
	.EP1_DIR_TX(EP1_DIR_TX));

/* File: bench/usbrx_mcu.sv */
// local processor model on the parallel bus
`timescale 1ns/1ps

module usbrx_mcu (
	input wire logic        clk,     // bus clock
	input wire logic [15:0] d_out,   // read data
	input wire logic [1:0]  pkt_rdy, // ready flags
	output logic            cs_b,    // select
	output logic            rd_b,    // read strobe
	output logic            wr_b,    // write strobe
	output logic            dack_b,  // dma ack
	output logic [7:0]      a,       // address
	output logic [15:0]     d_in     // write data
);
	// bus idle at time zero
	initial begin
		{cs_b, rd_b, wr_b, dack_b} = 4'hF;
		a = 8'h00;
		d_in = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// read: strobe held over the taking edge and the answer edge
	task automatic rd(input logic [7:0] ad, input logic dma, output logic [15:0] v);
		@(posedge clk);
		cs_b <= dma;
		dack_b <= !dma;
		rd_b <= 1'h0;
		a <= ad;
		repeat (2) @(posedge clk);
		v = d_out;
		{cs_b, rd_b, dack_b} <= 3'h7;
	endtask

	// write: released at the taking edge; the bus then floats to a changed value
	task automatic wr(input logic [7:0] ad, input logic [7:0] v);
		@(posedge clk);
		cs_b <= 1'h0;
		wr_b <= 1'h0;
		a <= ad;
		d_in <= {8'h00, v};
		@(posedge clk);
		{cs_b, wr_b} <= 2'h3;
		d_in <= ~{8'h00, v};
		@(posedge clk);
		#1;
	endtask

	// drain only once a stored packet is flagged, bounded wait
	task automatic wait_rdy(input int ep);
		for (int i = 0; i < 40 && pkt_rdy[ep] !== 1'h1; i++)
			@(posedge clk);
	endtask
endmodule

/* File: bench/usbrx_top_bench.sv */
// self-checking bench for the receive fifo access block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module usbrx_top_bench;
	import usbrx_pkg::*;
	logic        clk = 1'h0;
	logic        rst_b = 1'h0;
	logic        cs_b, rd_b, wr_b, dack_b, d_oe_b, stall0, stall1, dir_tx;
	logic [7:0]  a;
	logic [15:0] d_in, d_out, v;
	logic [1:0]  pkt_rdy;
	logic        rx_v = 1'h0, rx_ep = 1'h0, rx_done = 1'h0, rx_err = 1'h0;
	logic [7:0]  rx_d = 8'h00;
	logic [2:0]  ev = 3'h0;
	int          mismatches = 0;
	int          comparisons = 0;
	logic [7:0]  ro_a [4] = '{8'h20, 8'h21, 8'h30, 8'h31};
	logic [7:0]  ro_v [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
	logic [7:0]  ofs [12] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h32, 8'h33, 8'h34, 8'h35,
		8'h36, 8'h38, 8'h39, 8'h3A};
	logic [15:0] dma_exp [3] = '{16'h5150, 16'h5352, 16'h0054};

	always #5 clk = ~clk;

	usbrx_top u_usbrx_top (.CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .RD_B(rd_b), .WR_B(wr_b),
		.DACK_B(dack_b), .A(a), .D_IN(d_in), .D_OUT(d_out), .D_OE_B(d_oe_b), .RX_VALID(rx_v),
		.RX_EP(rx_ep), .RX_DATA(rx_d), .RX_DONE(rx_done), .RX_ERR(rx_err), .SETUP_SEEN(ev[0]),
		.OUT_TOKEN_EP1(ev[1]), .USB_BUS_RESET(ev[2]), .EP0_RX_CTRL_IN(ro_v[0]),
		.EP0_RX_TGL_IN(ro_v[1]), .EP0_TX_CTRL_IN(ro_v[2]), .EP0_TX_TGL_IN(ro_v[3]),
		.PKT_RDY(pkt_rdy), .EP0_STALL(stall0), .EP1_STALL(stall1), .EP1_DIR_TX(dir_tx));

	usbrx_mcu u_usbrx_mcu (.clk(clk), .d_out(d_out), .pkt_rdy(pkt_rdy), .cs_b(cs_b),
		.rd_b(rd_b), .wr_b(wr_b), .dack_b(dack_b), .a(a), .d_in(d_in));

	////////////////////////////////////////////////////////////////////////////
	// packet engine stand-in: bytes, then the end marker
	task automatic send(input logic ep, input int n, input logic err, input logic [7:0] b);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rx_v <= 1'h1;
			rx_ep <= ep;
			rx_d <= b + 8'(i);
		end
		@(posedge clk);
		rx_v <= 1'h0;
		rx_done <= 1'h1;
		rx_err <= err;
		@(posedge clk);
		{rx_done, rx_err} <= 2'h0;
		@(posedge clk);
		#1;
	endtask

	// one-cycle event: 0 setup, 1 out token, 2 bus reset
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev <= 3'h0;
		@(posedge clk);
		#1;
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog: the sequence needs a few hundred cycles, so this is ample
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end

	initial begin
		repeat (6) @(posedge clk);
		`CHK("reset flags", 2'h0, pkt_rdy)
		`CHK("reset oe", 1'h1, d_oe_b)
		`CHK("reset pins", 19'h00000, {stall0, stall1, dir_tx, d_out})
		rst_b <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			u_usbrx_mcu.rd(8'hC0 | ro_a[i], 1'h0, v);
			`CHK("ro reg", {8'h00, ro_v[i]}, v)
			`CHK("read oe", 1'h0, d_oe_b)
		end
		// data equals offset, so an address mix-up reads back wrong
		for (int i = 0; i < 12; i++) begin
			u_usbrx_mcu.rd(8'hC0 | ofs[i], 1'h0, v);
			`CHK("rw reset", {8'h00, RST_REG_VALUE}, v)
			u_usbrx_mcu.wr(8'h40 | ofs[i], ofs[i]);
			u_usbrx_mcu.rd(8'hC0 | ofs[i], 1'h0, v);
			`CHK("rw reg", {8'h00, ofs[i]}, v)
		end
		u_usbrx_mcu.rd(8'hE3, 1'h0, v);
		`CHK("reserved", {8'h00, UNMAPPED_READ}, v)
		$display("register test done");
		send(1'h0, 8, 1'h0, 8'h10);
		u_usbrx_mcu.wait_rdy(0);
		for (int i = 0; i < 9; i++) begin
			u_usbrx_mcu.rd(8'h40, 1'h0, v);
			`CHK("ep0 byte", (i < 8) ? 16'h0010 + 16'(i) : 16'h0000, v)
		end
		u_usbrx_mcu.wr(8'h48, 8'h01);
		`CHK("ep0 release", 1'h0, pkt_rdy[0])
		// each way of emptying ep0, k == 3 is a bad packet; one byte is taken first except for k == 3
		for (int k = 0; k < 5; k++) begin
			send(1'h0, 3, k == 3, 8'h30);
			`CHK("ep0 set", k != 3, pkt_rdy[0])
			u_usbrx_mcu.rd(8'h40, 1'h0, v);
			`CHK("ep0 first", (k == 3) ? 16'h0000 : 16'h0030, v)
			case (k)
				0: u_usbrx_mcu.wr(8'h48, 8'h01);
				1: pulse(0);
				2: u_usbrx_mcu.wr(8'h73, 8'h00);
				4: pulse(2);
				default: ;
			endcase
			`CHK("ep0 clear", 1'h0, pkt_rdy[0])
			u_usbrx_mcu.rd(8'h40, 1'h0, v);
			`CHK("ep0 empty", 16'h0000, v)
		end
		$display("ep0 test done");
		send(1'h1, 5, 1'h0, 8'h50);
		u_usbrx_mcu.wait_rdy(1);
		`CHK("ep1 set", 1'h1, pkt_rdy[1])
		for (int i = 0; i < 3; i++) begin
			u_usbrx_mcu.rd(8'h41, 1'h1, v);
			`CHK("ep1 dma", dma_exp[i], v)
		end
		send(1'h1, 2, 1'h0, 8'h60);
		pulse(1);
		`CHK("ep1 out clear", 1'h0, pkt_rdy[1])
		u_usbrx_mcu.rd(8'h41, 1'h0, v);
		`CHK("ep1 out flush", 16'h0000, v)
		// stall kept set so the direction changes do not empty the fifo
		send(1'h1, 2, 1'h0, 8'h70);
		u_usbrx_mcu.wr(8'h64, 8'h82);
		`CHK("ep1 ctrl pins", 2'h3, {dir_tx, stall1})
		u_usbrx_mcu.rd(8'hE0, 1'h0, v);
		u_usbrx_mcu.rd(8'h41, 1'h0, v);
		`CHK("ep1 tx hold", {8'h00, ro_v[0]}, v)
		u_usbrx_mcu.rd(8'h41, 1'h1, v);
		`CHK("ep1 tx dma hold", {8'h00, ro_v[0]}, v)
		u_usbrx_mcu.wr(8'h64, 8'h02);
		u_usbrx_mcu.rd(8'h41, 1'h0, v);
		`CHK("ep1 no pop", 16'h0070, v)
		u_usbrx_mcu.wr(8'h48, 8'h02);
		`CHK("ep1 release", 1'h0, pkt_rdy[1])
		u_usbrx_mcu.rd(8'h41, 1'h0, v);
		`CHK("ep1 release flush", 16'h0000, v)
		send(1'h1, 1, 1'h0, 8'h78);
		u_usbrx_mcu.wr(8'h64, 8'h00);
		`CHK("ep1 stall pins", 2'h0, {dir_tx, stall1})
		u_usbrx_mcu.rd(8'h41, 1'h0, v);
		`CHK("ep1 stall flush", 16'h0000, v)
		$display("ep1 test done");
		test_done();
	end
endmodule
